// ===== hw/sp2_cfg_pkg.sv
/*
 * Shared constants and types for the second serial port configuration block:
 * register indices, field positions, reset values, timing counts and carriers.
 * Assumes a 10 MHz system clock and a 32-bit APB register bus.
 */
package sp2_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned STEP_US = 100;
    localparam int unsigned STEP_CYC = (CLK_HZ / 1_000_000) * STEP_US;
    localparam int unsigned ASK_CARRIER_HZ = 500_000;
    localparam int unsigned ASK_HALF_CYC = CLK_HZ / (2 * ASK_CARRIER_HZ);

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [7:0] IDX_MODE = 8'hf0;
    localparam logic [7:0] IDX_IROPT = 8'hf1;
    localparam logic [7:0] IDX_HDTO = 8'hf2;
    localparam logic [7:0] IDX_DEVSEL = 8'h07;
    localparam logic [7:0] IDX_STATUS = 8'h08;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] IROPT_RST = 8'h02;
    localparam logic [7:0] HDTO_RST = 8'h03;
    localparam logic [7:0] DEVSEL_RST = 8'h00;
    localparam logic [7:0] SP2_DEV_NUM = 8'h05;
    localparam logic TX_IDLE_RST = 1'b0;

    localparam logic [7:0] MODE_WMASK = 8'h23;
    localparam logic [7:0] IROPT_WMASK = 8'h7f;

    localparam int unsigned MODE_MIDI_BIT = 0;
    localparam int unsigned MODE_HS_BIT = 1;
    localparam int unsigned MODE_IDLE_BIT = 5;
    localparam int unsigned IR_RXPOL_BIT = 0;
    localparam int unsigned IR_TXPOL_BIT = 1;
    localparam int unsigned IR_DUPLEX_BIT = 2;
    localparam int unsigned IR_MODE_LSB = 3;
    localparam int unsigned IR_LOC_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0]
    {
        IRM_COM = 3'h0,
        IRM_IRDA = 3'h1,
        IRM_ASK = 3'h2
    } ir_mode_e;

    typedef enum logic [1:0]
    {
        BLK_IDLE = 2'h0,
        BLK_BUSY = 2'h1,
        BLK_HOLD = 2'h3
    } blk_st_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_s;

    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

endpackage

// ===== hw/blank_timer.sv
/*
 * Half-duplex blanking timer: once one direction is active the other is
 * blanked, and the blanking is held for a programmed number of 100 us steps.
 * Assumes busy levels synchronous to CLK and a 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module blank_timer
    import sp2_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic half_duplex,
    input wire logic tx_busy,
    input wire logic rx_busy,
    input wire logic [7:0] timeout,
    output logic blank_rx,
    output logic blank_tx
);

    typedef struct packed {
        blk_st_e st;
        logic dir_tx;
        logic [9:0] cyc;
        logic [7:0] ticks;
    } blk_s;

    blk_s st_ff;
    blk_s nxt_st;
    logic busy_now;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_st = st_ff;
        busy_now = st_ff.dir_tx ? tx_busy : rx_busy;
        case (st_ff.st)
            BLK_IDLE:
            begin
                // Transmit wins a tie so our own echo never reaches the UART.
                if (tx_busy || rx_busy)
                begin
                    nxt_st.st = BLK_BUSY;
                    nxt_st.dir_tx = tx_busy;
                end
            end
            BLK_BUSY:
            begin
                if (!busy_now)
                begin
                    nxt_st.cyc = 10'h000;
                    nxt_st.ticks = timeout;
                    nxt_st.st = (timeout == 8'h00) ? BLK_IDLE : BLK_HOLD; // see (R13)
                end
            end
            BLK_HOLD:
            begin
                if (busy_now)
                begin
                    nxt_st.st = BLK_BUSY;
                end
                else if (st_ff.cyc == 10'(STEP_CYC - 1))
                begin
                    nxt_st.cyc = 10'h000;
                    nxt_st.ticks = st_ff.ticks - 8'h01; // see (R12)
                    if (st_ff.ticks == 8'h01)
                    begin
                        nxt_st.st = BLK_IDLE;
                    end
                end
                else
                begin
                    nxt_st.cyc = st_ff.cyc + 10'h001;
                end
            end
            default:
            begin
                nxt_st.st = BLK_IDLE;
            end
        endcase
        if (!half_duplex)
        begin
            nxt_st.st = BLK_IDLE;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_ff <= '{st: BLK_IDLE, dir_tx: 1'b0, cyc: 10'h000, ticks: 8'h00};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign blank_rx = (st_ff.st != BLK_IDLE) && st_ff.dir_tx; // see (R13)
    assign blank_tx = (st_ff.st != BLK_IDLE) && !st_ff.dir_tx; // see (R13)

endmodule

`default_nettype wire

// ===== hw/serial_port2_ir_config.sv
/*
 * Configuration and pin steering for the second serial port: mode register,
 * infrared options, half-duplex turnaround and an APB slave to reach them.
 * Assumes a UART core beside it that supplies serial data and a transmit
 * busy level, and that RESET covers the main power-on and host bus resets
 * while STANDBY_POR is the standby power-on reset.
 */
// Our own choice: register access over APB.
// Function
// (R1) Mode bit 0 enables MIDI support; cleared at reset.
// (R2) Mode bit 1 enables high-speed operation; cleared at reset.
// (R3) Mode bit 5 picks transmit idle level: driven low, or released.
// (R4) The idle-level bit is reset only by the standby power-on reset.
// (R5) Software writes zeros to mode bits 4..2 and 7..6.
// (R6) Infrared option bit 0 inverts receive polarity; active high at reset.
// (R7) Infrared option bit 1 inverts transmit polarity; active low at reset.
// (R8) Infrared option bit 2 selects half duplex; full duplex at reset.
// (R9) Bits 5..3 pick serial, IrDA or amplitude keyed infrared; others reserved.
// (R10) Infrared option bit 6 routes infrared to the alternate pins.
// (R11) Software writes zero to infrared option bit 7.
// (R12) Turnaround register counts blanking in 100 us steps.
// (R13) Zero blanks only during activity; each count adds 100 us.
// (R14) Writes need this logical device selected; reserved bits read zero.
`timescale 1ns/1ps
`default_nettype none

module serial_port2_ir_config
    import sp2_cfg_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic STANDBY_POR,
    input wire sp2_cfg_pkg::apb_req_s APB_REQ,
    output sp2_cfg_pkg::apb_rsp_s APB_RSP,
    input wire logic UART_TXD,
    input wire logic UART_TX_ACTIVE,
    output logic UART_RXD,
    output logic MIDI_EN,
    output logic HIGH_SPEED_EN,
    output logic [2:0] IR_MODE,
    output logic SERIAL_TX_OUT,
    output logic SERIAL_TX_OE_N,
    input wire logic SERIAL_RX_IN,
    output logic ALT_IR_TX_OUT,
    input wire logic ALT_IR_RX_IN
);

    import sp2_cfg_pkg::*;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] iropt;
        logic [7:0] hdto;
        logic [7:0] devsel;
        logic [31:0] prdata;
        logic [3:0] ask_div;
        logic ask_car;
        logic txo;
        logic txoe_n;
        logic alt_txo;
        logic rxd;
    } cfg_s;

    cfg_s st_ff;
    cfg_s nxt_st;
    logic tx_idle_ff;
    logic nxt_tx_idle;

    logic setup_ph;
    logic access_ph;
    logic wr_strobe;
    logic addr_hit;
    logic dev_sel;
    logic [7:0] rd_byte;
    ir_mode_e irm;
    logic ir_on;
    logic half_duplex;
    logic ir_rx_raw;
    logic ir_rx_act;
    logic ir_tx_act;
    logic ir_tx_pin;
    logic blank_rx;
    logic blank_tx;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode is needed for both the error response and the write strobe.
    function automatic logic is_mapped(input logic [11:0] a);
        return (a == byte_addr(IDX_MODE)) || (a == byte_addr(IDX_IROPT)) ||
            (a == byte_addr(IDX_HDTO)) || (a == byte_addr(IDX_DEVSEL)) ||
            (a == byte_addr(IDX_STATUS));
    endfunction

    assign setup_ph = APB_REQ.psel && !APB_REQ.penable;
    assign access_ph = APB_REQ.psel && APB_REQ.penable;
    assign addr_hit = is_mapped(APB_REQ.paddr);
    assign wr_strobe = access_ph && APB_REQ.pwrite && addr_hit;
    assign dev_sel = (st_ff.devsel == SP2_DEV_NUM);

    ////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; reserved bits are never stored, so they read as zero.
    always_comb
    begin
        rd_byte = 8'h00;
        if (APB_REQ.paddr == byte_addr(IDX_MODE))
        begin
            rd_byte = st_ff.mode;
            rd_byte[MODE_IDLE_BIT] = tx_idle_ff;
        end
        else if (APB_REQ.paddr == byte_addr(IDX_IROPT))
        begin
            rd_byte = st_ff.iropt; // see (R14)
        end
        else if (APB_REQ.paddr == byte_addr(IDX_HDTO))
        begin
            rd_byte = st_ff.hdto;
        end
        else if (APB_REQ.paddr == byte_addr(IDX_DEVSEL))
        begin
            rd_byte = st_ff.devsel;
        end
        else if (APB_REQ.paddr == byte_addr(IDX_STATUS))
        begin
            rd_byte = {4'h0, dev_sel, !st_ff.txoe_n, blank_tx, blank_rx};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Infrared path: mode, routing, polarity and half-duplex blanking.
    assign irm = ir_mode_e'(st_ff.iropt[IR_MODE_LSB +: 3]);
    // Reserved mode codes fall back to ordinary serial behaviour.
    assign ir_on = (irm == IRM_IRDA) || (irm == IRM_ASK); // see (R9)
    assign half_duplex = ir_on && st_ff.iropt[IR_DUPLEX_BIT]; // see (R8)
    assign ir_rx_raw = st_ff.iropt[IR_LOC_BIT] ? ALT_IR_RX_IN : SERIAL_RX_IN; // see (R10)
    assign ir_rx_act = ir_rx_raw ^ st_ff.iropt[IR_RXPOL_BIT]; // see (R6)

    blank_timer u_blank
    (
        .clk(CLK),
        .reset(RESET),
        .half_duplex(half_duplex),
        .tx_busy(UART_TX_ACTIVE),
        .rx_busy(ir_on && ir_rx_act),
        .timeout(st_ff.hdto), // see (R12)
        .blank_rx(blank_rx),
        .blank_tx(blank_tx)
    );

    // A zero data bit is sent as an active optical pulse; on the keyed
    // variant the pulse is chopped by the carrier.
    always_comb
    begin
        ir_tx_act = UART_TX_ACTIVE && !UART_TXD && !blank_tx;
        if (irm == IRM_ASK)
        begin
            ir_tx_act = ir_tx_act && st_ff.ask_car; // see (R9)
        end
        ir_tx_pin = ir_tx_act ^ st_ff.iropt[IR_TXPOL_BIT]; // see (R7)
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_st = st_ff;
        nxt_tx_idle = tx_idle_ff;

        if (setup_ph && !APB_REQ.pwrite)
        begin
            nxt_st.prdata = {24'h000000, rd_byte};
        end

        if (wr_strobe)
        begin
            if (APB_REQ.paddr == byte_addr(IDX_DEVSEL))
            begin
                nxt_st.devsel = APB_REQ.pwdata[7:0];
            end
            // Configuration writes are dropped while another device is selected.
            if (dev_sel) // see (R14)
            begin
                if (APB_REQ.paddr == byte_addr(IDX_MODE))
                begin
                    nxt_st.mode = APB_REQ.pwdata[7:0] & MODE_WMASK & ~(8'h01 << MODE_IDLE_BIT); // see (R1) (R2) (R5)
                    nxt_tx_idle = APB_REQ.pwdata[MODE_IDLE_BIT]; // see (R3)
                end
                if (APB_REQ.paddr == byte_addr(IDX_IROPT))
                begin
                    nxt_st.iropt = APB_REQ.pwdata[7:0] & IROPT_WMASK; // see (R11)
                end
                if (APB_REQ.paddr == byte_addr(IDX_HDTO))
                begin
                    nxt_st.hdto = APB_REQ.pwdata[7:0]; // see (R12)
                end
            end
        end

        // Carrier divider for the keyed infrared mode.
        if (st_ff.ask_div == 4'(ASK_HALF_CYC - 1))
        begin
            nxt_st.ask_div = 4'h0;
            nxt_st.ask_car = !st_ff.ask_car;
        end
        else
        begin
            nxt_st.ask_div = st_ff.ask_div + 4'h1;
        end

        // Serial transmit pin: carries UART data, infrared data, or idles.
        if (ir_on && !st_ff.iropt[IR_LOC_BIT])
        begin
            nxt_st.txo = ir_tx_pin; // see (R10)
            nxt_st.txoe_n = 1'b0;
        end
        else if (!ir_on && UART_TX_ACTIVE)
        begin
            nxt_st.txo = UART_TXD;
            nxt_st.txoe_n = 1'b0;
        end
        else
        begin
            // Releasing the pin lets an external pull set the line level.
            nxt_st.txo = 1'b0;
            nxt_st.txoe_n = tx_idle_ff; // see (R3)
        end

        // The alternate pin sits at its inactive level unless routed.
        if (ir_on && st_ff.iropt[IR_LOC_BIT])
        begin
            nxt_st.alt_txo = ir_tx_pin; // see (R10)
        end
        else
        begin
            nxt_st.alt_txo = st_ff.iropt[IR_TXPOL_BIT]; // see (R7)
        end

        // Receive data towards the UART; blanking holds the line at mark.
        if (!ir_on)
        begin
            nxt_st.rxd = SERIAL_RX_IN;
        end
        else if (blank_rx)
        begin
            nxt_st.rxd = 1'b1; // see (R8) (R13)
        end
        else
        begin
            nxt_st.rxd = !ir_rx_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Both resets clear the main state; only the standby reset clears the
    // idle-level bit, which lives on the standby supply.
    always_ff @(posedge CLK or posedge RESET or posedge STANDBY_POR)
    begin
        if (RESET || STANDBY_POR)
        begin
            st_ff.mode <= MODE_RST; // see (R1) (R2)
            st_ff.iropt <= IROPT_RST; // see (R6) (R7) (R8) (R10)
            st_ff.hdto <= HDTO_RST;
            st_ff.devsel <= DEVSEL_RST;
            st_ff.prdata <= 32'h00000000;
            st_ff.ask_div <= 4'h0;
            st_ff.ask_car <= 1'b0;
            st_ff.txo <= 1'b0;
            st_ff.txoe_n <= 1'b0;
            st_ff.alt_txo <= 1'b1;
            st_ff.rxd <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge CLK or posedge STANDBY_POR)
    begin
        if (STANDBY_POR)
        begin
            tx_idle_ff <= TX_IDLE_RST; // see (R4)
        end
        else
        begin
            tx_idle_ff <= nxt_tx_idle; // see (R4)
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Zero-wait slave: every access completes in its first access cycle.
    assign APB_RSP = '{
        prdata: st_ff.prdata,
        pready: 1'b1,
        pslverr: access_ph && !addr_hit
    };

    assign MIDI_EN = st_ff.mode[MODE_MIDI_BIT]; // see (R1)
    assign HIGH_SPEED_EN = st_ff.mode[MODE_HS_BIT]; // see (R2)
    assign IR_MODE = st_ff.iropt[IR_MODE_LSB +: 3];
    assign SERIAL_TX_OUT = st_ff.txo;
    assign SERIAL_TX_OE_N = st_ff.txoe_n;
    assign ALT_IR_TX_OUT = st_ff.alt_txo;
    assign UART_RXD = st_ff.rxd;

endmodule

`default_nettype wire

// ===== tb/sp2_cfg_sva.sv
/* Port checker for serial_port2_ir_config.
   Assumes the package and the design are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module sp2_cfg_chk
    import sp2_cfg_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic STANDBY_POR,
    input wire sp2_cfg_pkg::apb_req_s APB_REQ,
    input wire sp2_cfg_pkg::apb_rsp_s APB_RSP,
    input wire logic UART_TXD,
    input wire logic UART_TX_ACTIVE,
    input wire logic UART_RXD,
    input wire logic MIDI_EN,
    input wire logic HIGH_SPEED_EN,
    input wire logic [2:0] IR_MODE,
    input wire logic SERIAL_TX_OUT,
    input wire logic SERIAL_TX_OE_N,
    input wire logic SERIAL_RX_IN,
    input wire logic ALT_IR_TX_OUT,
    input wire logic ALT_IR_RX_IN
);
    logic sel_ff, idle_ff, acc, wr, com, ir, rx_act, tx_lvl, tpol;
    logic [7:0] iro_ff, d;
    logic [11:0] a;
    assign acc = APB_REQ.psel && APB_REQ.penable;
    assign wr = acc && APB_REQ.pwrite;
    assign a = APB_REQ.paddr;
    assign d = APB_REQ.pwdata[7:0];
    assign com = IR_MODE != 3'h1 && IR_MODE != 3'h2;
    assign ir = !com && !iro_ff[2];
    assign tpol = iro_ff[1];
    assign rx_act = (iro_ff[6] ? ALT_IR_RX_IN : SERIAL_RX_IN) ^ iro_ff[0];
    assign tx_lvl = (UART_TX_ACTIVE & ~UART_TXD) ^ iro_ff[1];
    ////////////////////////////////////////////////////////////////////////
    // Shadow of the select and option state, so pins can be judged.
    always_ff @(posedge CLK or posedge RESET or posedge STANDBY_POR)
    begin
        if (RESET || STANDBY_POR)
        begin
            sel_ff <= 1'b0;
            iro_ff <= 8'h02;
        end
        else if (wr && a == 12'h01c)
            sel_ff <= d == 8'h05;
        else if (wr && sel_ff && a == 12'h3c4)
            iro_ff <= d & 8'h7f;
    end
    // The idle bit lives on standby power and ignores the main reset.
    always_ff @(posedge CLK or posedge STANDBY_POR)
    begin
        if (STANDBY_POR)
            idle_ff <= 1'b0;
        else if (wr && sel_ff && a == 12'h3c0)
            idle_ff <= d[5];
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET || STANDBY_POR);
    mode_take_a:
        assert property (wr && sel_ff && a == 12'h3c0 |=> {HIGH_SPEED_EN, MIDI_EN} == 2'($past(d)))
        else $error("mode bits not taken");
    irmode_take_a:
        assert property (wr && sel_ff && a == 12'h3c4 |=> IR_MODE == 3'($past(d) >> 3))
        else $error("ir mode not taken");
    unsel_hold_a:
        assert property (wr && !sel_ff && (a == 12'h3c0 || a == 12'h3c4) |=> $stable(MIDI_EN) && $stable(IR_MODE))
        else $error("write taken while unselected");
    addr_err_a:
        assert property (acc |-> APB_RSP.pready && APB_RSP.pslverr == !(a inside {12'h3c0, 12'h3c4, 12'h3c8,
            12'h01c, 12'h020})) else $error("wrong bus response");
    reset_val_a:
        assert property ($fell(RESET) |-> !MIDI_EN && !HIGH_SPEED_EN && IR_MODE == 3'h0 && ALT_IR_TX_OUT)
        else $error("wrong reset state");
    idle_level_a:
        assert property (com && !UART_TX_ACTIVE |=> !SERIAL_TX_OUT && SERIAL_TX_OE_N == $past(idle_ff))
        else $error("wrong transmit idle state");
    com_tx_a:
        assert property (com && UART_TX_ACTIVE |=> SERIAL_TX_OUT == $past(UART_TXD) && !SERIAL_TX_OE_N)
        else $error("serial transmit not passed");
    com_rx_a:
        assert property (com |=> UART_RXD == $past(SERIAL_RX_IN) && ALT_IR_TX_OUT == $past(tpol))
        else $error("serial receive not passed");
    ir_rx_a:
        assert property (ir |=> UART_RXD == !$past(rx_act))
        else $error("ir receive wrong");
    ir_tx_ser_a:
        assert property (ir && IR_MODE == 3'h1 && !iro_ff[6] |=> SERIAL_TX_OUT == $past(tx_lvl) && !SERIAL_TX_OE_N)
        else $error("ir transmit wrong on serial pin");
    ir_tx_alt_a:
        assert property (ir && IR_MODE == 3'h1 && iro_ff[6] |=> ALT_IR_TX_OUT == $past(tx_lvl))
        else $error("ir transmit wrong on alternate pin");
    cover property (wr && sel_ff && a == 12'h3c0);
    cover property (acc && APB_RSP.pslverr);
    cover property (!com && iro_ff[2] && UART_TX_ACTIVE ##1 !UART_TX_ACTIVE);
endmodule
bind serial_port2_ir_config sp2_cfg_chk chk (.CLK, .RESET, .STANDBY_POR, .APB_REQ, .APB_RSP, .UART_TXD,
    .UART_TX_ACTIVE, .UART_RXD, .MIDI_EN, .HIGH_SPEED_EN, .IR_MODE, .SERIAL_TX_OUT, .SERIAL_TX_OE_N,
    .SERIAL_RX_IN, .ALT_IR_TX_OUT, .ALT_IR_RX_IN);
`default_nettype wire

// ===== tb/ir_line_model.sv
/* Far-side line: drives the serial and alternate receive pins.
   Assumes the bench says when and on which pin traffic runs. */
`timescale 1ns/1ps
`default_nettype none
module ir_line_model
(
    input wire logic clk,
    input wire logic send,
    input wire logic level,
    input wire logic use_alt,
    output logic serial_rx,
    output logic alt_rx
);
    logic tog = 1'b0;
    // An unused alternate pin wanders, so a wrong route shows up.
    always @(posedge clk)
        tog <= ~tog;
    always_comb
    begin
        serial_rx = (send && !use_alt) ? level : 1'b1;
        alt_rx = (send && use_alt) ? level : tog;
    end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
/* Random and corner-case bench for serial_port2_ir_config.
   Assumes the package, the design, the checker and the line model. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sp2_cfg_pkg::*;
    logic clk = 0, rst = 1, sby = 1, txd = 1, tx_act = 0, rx_lvl = 0, rx_alt = 0, err;
    logic rxd, midi, hs, tx_out, oe_n, ser_rx, alt_tx, alt_rx;
    logic [2:0] ir_mode;
    logic [31:0] rd;
    apb_req_s req = '0;
    apb_rsp_s rsp;
    int num_errors = 0;
    int checks_done = 0;
    always #50 clk = ~clk;
    serial_port2_ir_config dut (.CLK(clk), .RESET(rst), .STANDBY_POR(sby), .APB_REQ(req), .APB_RSP(rsp),
        .UART_TXD(txd), .UART_TX_ACTIVE(tx_act), .UART_RXD(rxd), .MIDI_EN(midi), .HIGH_SPEED_EN(hs),
        .IR_MODE(ir_mode), .SERIAL_TX_OUT(tx_out), .SERIAL_TX_OE_N(oe_n), .SERIAL_RX_IN(ser_rx),
        .ALT_IR_TX_OUT(alt_tx), .ALT_IR_RX_IN(alt_rx));
    ir_line_model line (.clk(clk), .send(1'b1), .level(rx_lvl), .use_alt(rx_alt), .serial_rx(ser_rx),
        .alt_rx(alt_rx));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] dat);
        int n;
        n = 0;
        req <= '{1'b1, 1'b0, w, {2'h0, idx, 2'h0}, {24'($urandom()), dat}};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1 && n < 16)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 16)
            num_errors++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic rdchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(what, {24'h0, exp}, rd);
    endtask
    task automatic pulse(input logic standby);
        if (standby)
            sby <= 1'b1;
        else
            rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sby <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [7:0] keep(input logic [7:0] idx, input logic [7:0] v);
        return idx == 8'hf0 ? v & 8'h23 : idx == 8'hf1 ? v & 8'h7f : v;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #1_000_000;
        num_errors++;
        tally_and_finish();
    end
    initial
    begin
        logic [7:0] idx, v;
        void'($urandom(3781));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sby <= 1'b0;
        @(posedge clk);
        rdchk("mode reset", 8'hf0, 8'h00);
        rdchk("option reset", 8'hf1, 8'h02);
        rdchk("turnaround reset", 8'hf2, 8'h03);
        xfer(1'b1, 8'hf0, 8'h03);
        rdchk("unselected write", 8'hf0, 8'h00);
        xfer(1'b1, 8'h07, 8'h05);
        xfer(1'b1, 8'hf0, 8'hdf);
        rdchk("mode reserved", 8'hf0, keep(8'hf0, 8'hdf));
        chk("midi and speed", 32'h3, {30'h0, hs, midi});
        xfer(1'b1, 8'hf1, 8'hfb);
        rdchk("option reserved", 8'hf1, keep(8'hf1, 8'hfb));
        xfer(1'b0, 8'h40, 8'h00);
        chk("unmapped error", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        $display("register access test done");
        // Software keeps reserved bits zero; half duplex stays off here.
        repeat (12)
        begin
            idx = 8'hf0 + 8'($urandom_range(2));
            v = keep(idx, 8'($urandom())) & (idx == 8'hf1 ? 8'hfb : 8'hff);
            xfer(1'b1, idx, v);
            rdchk("random readback", idx, v);
        end
        $display("random register test done");
        for (int m = 0; m < 8; m++)
        begin
            v = {1'b0, 1'($urandom()), 3'(m), 1'b0, 2'($urandom())};
            xfer(1'b1, 8'hf1, v);
            rx_alt <= v[6];
            chk("ir mode", 32'(m), {29'h0, ir_mode});
            repeat (20)
            begin
                @(posedge clk);
                txd <= 1'($urandom());
                tx_act <= 1'($urandom());
                rx_lvl <= 1'($urandom());
            end
        end
        tx_act <= 1'b0;
        rx_lvl <= 1'b0;
        rx_alt <= 1'b0;
        $display("mode and pin test done");
        xfer(1'b1, 8'hf1, 8'h02);
        xfer(1'b1, 8'hf0, 8'h20);
        @(negedge clk);
        chk("idle released", 32'h1, {31'h0, oe_n});
        @(posedge clk);
        pulse(1'b0);
        rdchk("idle kept", 8'hf0, 8'h20);
        chk("idle kept pin", 32'h1, {31'h0, oe_n});
        pulse(1'b1);
        rdchk("idle cleared", 8'hf0, 8'h00);
        chk("idle driven", 32'h0, {31'h0, oe_n});
        $display("idle level test done");
        xfer(1'b1, 8'h07, 8'h05);
        xfer(1'b1, 8'hf1, 8'h0c);
        txd <= 1'b0;
        for (int n = 0; n < 2; n++)
        begin
            rx_lvl <= 1'b0;
            repeat (3) @(posedge clk);
            xfer(1'b1, 8'hf2, 8'(n));
            tx_act <= 1'b1;
            repeat (3) @(posedge clk);
            rx_lvl <= 1'b1;
            repeat (3) @(posedge clk);
            tx_act <= 1'b0;
            if (n == 0)
                repeat (4) @(posedge clk);
            else
            begin
                repeat (900) @(posedge clk);
                xfer(1'b0, 8'h08, 8'h00);
                chk("blank status", 32'h1, {31'h0, rd[0]});
                repeat (86) @(posedge clk);
                @(negedge clk);
                chk("blank hold", 32'h1, {31'h0, rxd});
                repeat (20) @(posedge clk);
            end
            @(negedge clk);
            chk("blank over", 32'h0, {31'h0, rxd});
            @(posedge clk);
        end
        $display("half duplex test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
